// file: inc/postbyte_pkg.sv
/*
  shared constants and carrier types for the indexed postbyte decoder.
  assumes a single 50 MHz core clock and byte-wide instruction queue.
*/
package postbyte_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int WORD_W = 16;              // address and register width
  localparam int BYTE_W = 8;               // queue byte width

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] PAGE2_PREFIX = 8'h18;  // second opcode page prefix
  localparam logic [2:0] LONG_TAG     = 3'h7;   // bits 7:5 of long forms
  localparam logic [1:0] SEL_X        = 2'h0;   // base select codes
  localparam logic [1:0] SEL_Y        = 2'h1;
  localparam logic [1:0] SEL_SP       = 2'h2;
  localparam logic [1:0] SEL_PC       = 2'h3;
  localparam logic [1:0] ACC_A        = 2'h0;   // accumulator select codes
  localparam logic [1:0] ACC_B        = 2'h1;
  localparam logic [1:0] ACC_D        = 2'h2;
  localparam logic [1:0] ACC_D_IND    = 2'h3;
  localparam int BIT_FIVE  = 5;            // short form / auto-adjust split
  localparam int BIT_ADJ_P = 4;            // pre/post select
  localparam int BIT_Z     = 1;            // 9/16-bit select
  localparam int BIT_S     = 0;            // 9-bit sign

  // ---------------------------------------------------------------
  // form classes
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    FORM_SHORT   = 8'h01,  // indexed_short_form, 5-bit constant
    FORM_NINE    = 8'h02,  // indexed_nine_bit_form
    FORM_SIXTEEN = 8'h04,  // indexed_sixteen_bit_form
    FORM_IND16   = 8'h08,  // 16-bit offset indirect
    FORM_AUTO    = 8'h10,  // auto pre/post adjust
    FORM_ACC     = 8'h20,  // accumulator offset
    FORM_IND_D   = 8'h40,  // accumulator D indirect
    FORM_BAD     = 8'h80   // illegal encoding
  } form_t;

  typedef struct packed {
    logic [WORD_W-1:0] x;
    logic [WORD_W-1:0] y;
    logic [WORD_W-1:0] sp;
    logic [WORD_W-1:0] pc;
    logic [BYTE_W-1:0] acc_a;
    logic [BYTE_W-1:0] acc_b;
  } regs_t;

  typedef struct packed {
    form_t             form;
    logic [1:0]        base_register_select;
    logic [1:0]        ext_bytes;      // extension bytes that follow
    logic              indirect;       // pointer fetch needed
    logic              writeback;      // index register updated
    logic [WORD_W-1:0] ea;             // effective or pointer address
    logic [WORD_W-1:0] wb_value;       // adjusted index value
  } decode_t;

endpackage

// file: hdl/postbyte_form.sv
/*
  combinational classifier for one indexed postbyte.
  assumes the caller registers the result; no state here.
*/
`timescale 1ns/1ps
module postbyte_form (
  input  wire logic [7:0]          index_postbyte_in,  // postbyte under test
  output postbyte_pkg::form_t      form_out,           // decoded form
  output logic [1:0]               ext_bytes_out       // extension byte count
);
  import postbyte_pkg::*;

  // ---------------------------------------------------------------
  // classification
  // ---------------------------------------------------------------
  // pure decode of the bit patterns
  always_comb begin
    form_out      = FORM_BAD;
    ext_bytes_out = 2'h0;
    if (!index_postbyte_in[BIT_FIVE]) begin
      form_out = FORM_SHORT;
    end else if (index_postbyte_in[7:5] != LONG_TAG) begin
      // pc select is not a legal auto-adjust base
      form_out = (index_postbyte_in[7:6] == SEL_PC) ? FORM_BAD : FORM_AUTO;
    end else if (!index_postbyte_in[2]) begin
      if (!index_postbyte_in[BIT_Z]) begin
        form_out      = FORM_NINE;
        ext_bytes_out = 2'h1;
      end else if (index_postbyte_in[BIT_S]) begin
        form_out      = FORM_IND16;
        ext_bytes_out = 2'h2;
      end else begin
        form_out      = FORM_SIXTEEN;
        ext_bytes_out = 2'h2;
      end
    end else if (index_postbyte_in[1:0] == ACC_D_IND) begin
      form_out = FORM_IND_D;
    end else begin
      form_out = FORM_ACC;
    end
  end

endmodule

// file: hdl/indexed_postbyte_decoder.sv
/*
  indexed postbyte decoder: takes opcode/postbyte/extension bytes from the
  instruction queue and produces base select, form, effective address and
  index writeback. assumes the queue presents one byte per cycle with valid,
  and that register values are stable while a postbyte is decoded.
*/
// Function
// - 111rr0zs: z0 nine-bit signed, z1 sixteen-bit
// - 111rr011: sixteen-bit offset indexed-indirect
// - auto-adjust: p pre/post, step +1..+8, -1..-8
// - auto-adjust base only X, Y or SP
// - accumulator offset: A, B or D unsigned
// - accumulator select 11: D indexed-indirect
// - fetch zero, one or two extension bytes
// - $18 prefix selects second opcode page
// - accept postbytes and extension bytes after opcode
// - nine-bit: low byte extension, sign from postbyte
// - D-indirect pointer at base plus D
`timescale 1ns/1ps
module indexed_postbyte_decoder (
  input  wire logic                          mclk_in,          // core bus clock
  input  wire logic                          rstn_in,          // synchronous reset, active low
  input  wire logic                          byte_valid_in,    // queue byte present
  input  wire logic [7:0]                    byte_in,          // queue byte
  input  wire logic                          opcode_in,        // byte is an opcode start
  input  wire logic                          wants_post_in,    // current opcode takes a postbyte
  input  wire logic                          post_indexed_in,  // that postbyte is indexed form
  input  wire logic [1:0]                    other_ext_in,     // extension bytes for non-indexed ops
  input  wire postbyte_pkg::regs_t           regs_in,          // programmer model values
  output logic                               byte_ready_out,   // decoder takes the byte
  output logic                               page2_out,        // opcode from second page
  output logic [7:0]                         opcode_out,       // latched opcode
  output logic [7:0]                         postbyte_out,     // latched postbyte, indexed or not
  output postbyte_pkg::decode_t              decode_out,       // indexed decode result
  output logic                               done_out          // one-cycle result pulse
);
  import postbyte_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_OPCODE = 5'h01,  // waiting for opcode or prefix
    ST_PAGE2  = 5'h02,  // prefix seen, waiting for page-two opcode
    ST_POST   = 5'h04,  // waiting for postbyte
    ST_EXT    = 5'h08,  // collecting extension bytes
    ST_CALC   = 5'h10   // form effective address
  } state_t;

  state_t            state_ff,    nxt_state;
  logic              page2_ff,    nxt_page2;
  logic [7:0]        opcode_ff,   nxt_opcode;
  logic [7:0]        post_ff,     nxt_post;
  logic              indexed_ff,  nxt_indexed;   // postbyte is indexed
  logic [1:0]        need_ff,     nxt_need;      // extension bytes left
  logic [WORD_W-1:0] ext_ff,      nxt_ext;       // collected extension, msb first
  decode_t           decode_ff,   nxt_decode;
  logic              done_ff,     nxt_done;
  form_t             form_ff,     nxt_form;      // pending form, published only at done
  logic [1:0]        cnt_ff,      nxt_cnt;       // pending extension count, published at done

  form_t             form_w;      // classifier result for incoming byte
  logic [1:0]        ext_cnt_w;   // its extension count

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // base register pick, shared by every indexed form
  function automatic logic [WORD_W-1:0] base_of(input regs_t r, input logic [1:0] sel);
    logic [WORD_W-1:0] v;
    v = r.pc;
    if (sel == SEL_X)       v = r.x;
    else if (sel == SEL_Y)  v = r.y;
    else if (sel == SEL_SP) v = r.sp;
    return v;
  endfunction

  // base select field: bits 4:3 in the long forms, bits 7:6 everywhere else
  function automatic logic [1:0] sel_of(input logic [7:0] pb);
    logic [1:0] s;
    s = (pb[7:5] == LONG_TAG) ? pb[4:3] : pb[7:6];
    return s;
  endfunction

  // auto-adjust step: 0000..0111 is +1..+8, 1000..1111 is -8..-1
  function automatic logic [WORD_W-1:0] step_of(input logic [3:0] n);
    logic [WORD_W-1:0] s;
    s = n[3] ? {{(WORD_W-4){1'b1}}, n} : {{(WORD_W-4){1'b0}}, n} + 16'h0001;
    return s;
  endfunction

  postbyte_form u_form (
    .index_postbyte_in (byte_in),
    .form_out          (form_w),
    .ext_bytes_out     (ext_cnt_w)
  );

  // byte taken whenever the decoder is not busy computing
  assign byte_ready_out = (state_ff != ST_CALC);
  assign page2_out      = page2_ff;
  assign opcode_out     = opcode_ff;
  assign postbyte_out   = post_ff;
  assign decode_out     = decode_ff;
  assign done_out       = done_ff;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [WORD_W-1:0] base;
    logic [WORD_W-1:0] adj;
    logic [WORD_W-1:0] off;
    base        = base_of(regs_in, sel_of(post_ff));
    adj         = base + step_of(post_ff[3:0]);
    off         = 16'h0000;
    nxt_state   = state_ff;
    nxt_page2   = page2_ff;
    nxt_opcode  = opcode_ff;
    nxt_post    = post_ff;
    nxt_indexed = indexed_ff;
    nxt_need    = need_ff;
    nxt_ext     = ext_ff;
    nxt_decode  = decode_ff;
    nxt_form    = form_ff;
    nxt_cnt     = cnt_ff;
    nxt_done    = 1'b0;
    case (state_ff)
      ST_OPCODE, ST_PAGE2: begin
        if (byte_valid_in && opcode_in) begin
          if (state_ff == ST_OPCODE && byte_in == PAGE2_PREFIX) begin
            nxt_state = ST_PAGE2;
            nxt_page2 = 1'b1;
          end else begin
            nxt_opcode  = byte_in;
            nxt_page2   = (state_ff == ST_PAGE2);
            nxt_indexed = 1'b0;
            nxt_need    = other_ext_in;
            nxt_ext     = 16'h0000;
            nxt_form    = FORM_BAD;                              // no postbyte: not indexed
            nxt_cnt     = other_ext_in;
            if (wants_post_in)       nxt_state = ST_POST;
            else if (other_ext_in != 2'h0) nxt_state = ST_EXT;
            else                     nxt_state = ST_CALC;
          end
        end
      end
      ST_POST: begin
        if (byte_valid_in) begin
          nxt_post    = byte_in;
          nxt_indexed = post_indexed_in;
          if (post_indexed_in) nxt_need = ext_cnt_w;
          // kept aside so the published result only moves together with done
          nxt_form = post_indexed_in ? form_w : FORM_BAD;
          nxt_cnt  = post_indexed_in ? ext_cnt_w : other_ext_in;
          nxt_state = ((post_indexed_in ? ext_cnt_w : nxt_need) != 2'h0) ? ST_EXT : ST_CALC;
        end
      end
      ST_EXT: begin
        if (byte_valid_in) begin
          nxt_ext  = {ext_ff[BYTE_W-1:0], byte_in};
          nxt_need = need_ff - 2'h1;
          if (need_ff == 2'h1) nxt_state = ST_CALC;
        end
      end
      ST_CALC: begin
        nxt_done             = 1'b1;
        nxt_state            = ST_OPCODE;
        nxt_page2            = 1'b0;
        nxt_decode.indirect  = 1'b0;
        nxt_decode.writeback = 1'b0;
        nxt_decode.wb_value  = base;
        nxt_decode.form      = form_ff;
        nxt_decode.ext_bytes = cnt_ff;
        nxt_decode.base_register_select = sel_of(post_ff);
        case (form_ff)
          FORM_SHORT: off = {{(WORD_W-5){post_ff[4]}}, post_ff[4:0]};
          FORM_NINE: off = {{(WORD_W-8){post_ff[BIT_S]}}, ext_ff[7:0]};
          FORM_SIXTEEN: off = ext_ff;
          FORM_IND16: begin
            off                 = ext_ff;
            nxt_decode.indirect = 1'b1;
          end
          FORM_ACC: begin
            if (post_ff[1:0] == ACC_A)      off = {8'h00, regs_in.acc_a};
            else if (post_ff[1:0] == ACC_B) off = {8'h00, regs_in.acc_b};
            else                            off = {regs_in.acc_a, regs_in.acc_b};
          end
          FORM_IND_D: begin
            off                 = {regs_in.acc_a, regs_in.acc_b};
            nxt_decode.indirect = 1'b1;
          end
          FORM_AUTO: begin
            nxt_decode.writeback = 1'b1;
            nxt_decode.wb_value  = adj;
          end
          default: off = 16'h0000;                               // illegal: plain base
        endcase
        // auto forms bypass the adder: pre uses adjusted, post the original
        if (form_ff == FORM_AUTO)
          nxt_decode.ea = post_ff[BIT_ADJ_P] ? base : adj;
        else
          nxt_decode.ea = base + off;
        if (!indexed_ff) begin
          nxt_decode.ea = ext_ff;                                // non-indexed: raw extension
          nxt_decode.writeback = 1'b0;
        end
      end
      default: nxt_state = ST_OPCODE;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      state_ff   <= ST_OPCODE;
      page2_ff   <= 1'b0;
      opcode_ff  <= 8'h00;
      post_ff    <= 8'h00;
      indexed_ff <= 1'b0;
      need_ff    <= 2'h0;
      ext_ff     <= 16'h0000;
      decode_ff  <= '{form: FORM_BAD, default: '0};
      done_ff    <= 1'b0;
      form_ff    <= FORM_BAD;
      cnt_ff     <= 2'h0;
    end else begin
      state_ff   <= nxt_state;
      page2_ff   <= nxt_page2;
      opcode_ff  <= nxt_opcode;
      post_ff    <= nxt_post;
      indexed_ff <= nxt_indexed;
      need_ff    <= nxt_need;
      ext_ff     <= nxt_ext;
      decode_ff  <= nxt_decode;
      done_ff    <= nxt_done;
      form_ff    <= nxt_form;
      cnt_ff     <= nxt_cnt;
    end
  end

endmodule

// file: verif/postbyte_queue_model.sv
/*
  instruction queue stand-in: offers one byte a cycle with its qualifiers.
  assumes the bench calls put and idle from a single process.
*/
`timescale 1ns/1ps
module postbyte_queue_model (
  input  wire logic       mclk_in,          // core clock
  input  wire logic       byte_ready_in,    // decoder takes the byte
  output logic            byte_valid_out,   // byte on offer
  output logic [7:0]      byte_out,         // offered byte
  output logic            opcode_out,       // byte starts an instruction
  output logic            wants_post_out,   // opcode takes a postbyte
  output logic            post_indexed_out  // postbyte is indexed
);
  // ---------------------------------------------------------------
  // queue tasks
  // ---------------------------------------------------------------
  initial begin
    byte_valid_out = 1'b0;
    byte_out = 8'hA5;
    opcode_out = 1'b0;
    wants_post_out = 1'b0;
    post_indexed_out = 1'b0;
  end

  // ready is read at the falling edge where it is settled, never at the taking edge
  task automatic put(input logic [7:0] b, input logic op, input logic wp, input logic ix);
    int n;
    @(negedge mclk_in);
    byte_valid_out = 1'b1;
    byte_out = b;
    opcode_out = op;
    wants_post_out = wp;
    post_indexed_out = ix;
    n = 0;
    while (byte_ready_in !== 1'b1 && n < 16) begin
      @(negedge mclk_in);
      n++;
    end
    @(posedge mclk_in);
  endtask

  // released byte lane shows the inverse, so a stale value never looks valid
  task automatic idle();
    @(negedge mclk_in);
    byte_valid_out = 1'b0;
    byte_out = ~byte_out;
    opcode_out = 1'b0;
  endtask
endmodule

// file: verif/indexed_postbyte_decoder_chk.sv
/*
  port checker for the indexed postbyte decoder.
  assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module indexed_postbyte_decoder_chk
  import postbyte_pkg::*;
(
  input wire logic       mclk_in,         // core clock
  input wire logic       rstn_in,         // reset, active low
  input wire logic       byte_valid_in,   // queue byte present
  input wire logic [7:0] byte_in,         // queue byte
  input wire logic       byte_ready_out,  // decoder takes the byte
  input wire logic       page2_out,       // second page opcode
  input wire logic       done_out,        // result pulse
  input wire decode_t    decode_out       // decode result
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  a_calc_then_done: assert property (!byte_ready_out |=> done_out && byte_ready_out)
    else $error("done did not follow the busy cycle");
  a_done_pulse: assert property (done_out |=> !done_out && $stable(decode_out))
    else $error("done longer than one cycle");
  a_decode_hold: assert property (!done_out |-> $stable(decode_out))
    else $error("decode changed without done");
  a_short_noext: assert property (done_out && decode_out.form == FORM_SHORT |->
    decode_out.ext_bytes == 2'h0 && !decode_out.indirect && !decode_out.writeback)
    else $error("short form flags wrong");
  a_nine_oneext: assert property (done_out && decode_out.form == FORM_NINE |->
    decode_out.ext_bytes == 2'h1 && !decode_out.indirect)
    else $error("nine bit form flags wrong");
  a_long_twoext: assert property (done_out && decode_out.form == FORM_SIXTEEN |->
    decode_out.ext_bytes == 2'h2 && !decode_out.indirect)
    else $error("sixteen bit form flags wrong");
  a_ind16_ptr: assert property (done_out && decode_out.form == FORM_IND16 |->
    decode_out.ext_bytes == 2'h2 && decode_out.indirect)
    else $error("indirect sixteen flags wrong");
  a_accd_ptr: assert property (done_out && decode_out.form == FORM_IND_D |->
    decode_out.indirect && decode_out.ext_bytes == 2'h0)
    else $error("accumulator indirect flags wrong");
  a_auto_base: assert property (done_out && decode_out.form == FORM_AUTO |->
    decode_out.base_register_select != SEL_PC && decode_out.writeback)
    else $error("auto adjust base or writeback wrong");
  a_page2_cause: assert property ($rose(page2_out) |->
    $past(byte_in, 2) == PAGE2_PREFIX || $past(byte_in) == PAGE2_PREFIX)
    else $error("second page without prefix");

  c_auto: cover property (done_out && decode_out.form == FORM_AUTO);
  c_ind_d: cover property (done_out && decode_out.form == FORM_IND_D);
  c_page2: cover property ($rose(page2_out));
endmodule

bind indexed_postbyte_decoder indexed_postbyte_decoder_chk i_chk (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .byte_valid_in(byte_valid_in), .byte_in(byte_in), .byte_ready_out(byte_ready_out),
  .page2_out(page2_out), .done_out(done_out), .decode_out(decode_out));

// file: verif/indexed_postbyte_decoder_bench.sv
/*
  self-checking bench: corner and random postbytes through the queue model.
  assumes a 50 MHz clock and registers held steady until done.
*/
`timescale 1ns/1ps
module indexed_postbyte_decoder_bench;
  import postbyte_pkg::*;
  logic        mclk_in = 1'b0;          // core clock
  logic        rstn_in;                 // reset, active low
  logic        byte_valid_in, opcode_in, wants_post_in, post_indexed_in;
  logic [7:0]  byte_in, opcode_out, postbyte_out;
  logic [1:0]  other_ext_in;            // extension count for non-indexed ops
  logic [31:0] rnd;                     // one random draw for the random loop
  regs_t       regs_in;                 // programmer model values
  logic        byte_ready_out, page2_out, done_out;
  decode_t     decode_out;              // decode result
  int          num_errors, checks_done, cycles;
  logic [31:0] seed = 32'h0000816C;     // fixed start keeps runs repeatable
  logic [7:0]  corner [16] = '{8'h00, 8'h10, 8'hCF, 8'h27, 8'h28, 8'h3F, 8'h70, 8'hB8,
                               8'hE0, 8'hE1, 8'hE2, 8'hEB, 8'hE4, 8'hED, 8'hF6, 8'hFF};

  always #10 mclk_in = ~mclk_in;

  postbyte_queue_model i_postbyte_queue_model (.mclk_in(mclk_in), .byte_ready_in(byte_ready_out),
    .byte_valid_out(byte_valid_in), .byte_out(byte_in), .opcode_out(opcode_in),
    .wants_post_out(wants_post_in), .post_indexed_out(post_indexed_in));
  indexed_postbyte_decoder i_indexed_postbyte_decoder (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .byte_valid_in(byte_valid_in), .byte_in(byte_in), .opcode_in(opcode_in),
    .wants_post_in(wants_post_in), .post_indexed_in(post_indexed_in), .other_ext_in(other_ext_in),
    .regs_in(regs_in), .byte_ready_out(byte_ready_out), .page2_out(page2_out),
    .opcode_out(opcode_out), .postbyte_out(postbyte_out), .decode_out(decode_out), .done_out(done_out));

  // ---------------------------------------------------------------
  // expectation helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] base_of(input logic [1:0] s);
    case (s)
      SEL_X:   return regs_in.x;
      SEL_Y:   return regs_in.y;
      SEL_SP:  return regs_in.sp;
      default: return regs_in.pc;
    endcase
  endfunction

  function automatic decode_t predict(input logic [7:0] pb, input logic [15:0] e);
    decode_t     d;
    logic        lng;
    logic [15:0] b, st;
    d = '0;
    lng = (pb[7:5] == LONG_TAG);
    d.base_register_select = lng ? pb[4:3] : pb[7:6];
    b = base_of(d.base_register_select);
    st = pb[3] ? {12'hFFF, pb[3:0]} : {12'h000, pb[3:0]} + 16'h0001;
    if (!pb[5]) begin
      d.form = FORM_SHORT;
      d.ea = b + {{11{pb[4]}}, pb[4:0]};
    end else if (!lng) begin
      d.form = FORM_AUTO;
      d.writeback = 1'b1;
      d.wb_value = b + st;
      d.ea = pb[4] ? b : b + st;
    end else if (!pb[2]) begin
      d.ext_bytes = pb[1] ? 2'h2 : 2'h1;
      d.indirect = pb[1] & pb[0];
      d.form = !pb[1] ? FORM_NINE : (pb[0] ? FORM_IND16 : FORM_SIXTEEN);
      d.ea = b + (pb[1] ? e : {{8{pb[0]}}, e[7:0]});
    end else begin
      d.indirect = (pb[1:0] == ACC_D_IND);
      d.form = d.indirect ? FORM_IND_D : FORM_ACC;
      d.ea = b + (pb[1] ? {regs_in.acc_a, regs_in.acc_b} : {8'h00, pb[0] ? regs_in.acc_b : regs_in.acc_a});
    end
    return d;
  endfunction

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
    checks_done++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, want, seen);
    end
  endtask

  // one instruction: [prefix] opcode postbyte [ext msb first], then busy and done
  task automatic run_one(input logic [7:0] pb, input logic p2, input logic ix);
    decode_t     d;
    logic [15:0] e;
    logic [7:0]  op;
    logic [1:0]  n;
    logic [31:0] r;
    logic [95:0] w;
    r = xs();
    e = r[15:0];
    op = r[23:16];
    if (op == PAGE2_PREFIX) op = 8'h19;
    @(negedge mclk_in);
    w = {xs(), xs(), xs()};
    regs_in = w[79:0];
    d = predict(pb, e);
    n = ix ? d.ext_bytes : other_ext_in;
    if (p2) i_postbyte_queue_model.put(PAGE2_PREFIX, 1'b1, 1'b0, 1'b0);
    i_postbyte_queue_model.put(op, 1'b1, 1'b1, 1'b0);
    i_postbyte_queue_model.put(pb, 1'b0, 1'b0, ix);
    #1 check("page2", page2_out, p2);
    if (n == 2'h2) i_postbyte_queue_model.put(e[15:8], 1'b0, 1'b0, 1'b0);
    if (n != 2'h0) i_postbyte_queue_model.put(e[7:0], 1'b0, 1'b0, 1'b0);
    i_postbyte_queue_model.idle();
    check("ready", byte_ready_out, 1'b0);
    @(negedge mclk_in);
    check("done", done_out, 1'b1);
    check("opcode", opcode_out, op);
    if (!ix) check("postbyte", postbyte_out, pb);
    if (!ix) check("form", decode_out.form, FORM_BAD);
    if (!ix) check("raw ea", decode_out.ea, e);
    if (ix) check("decode", decode_out[45:16], d[45:16]);
    if (ix && d.writeback) check("adjusted", decode_out.wb_value, d.wb_value);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence and hang guard
  // ---------------------------------------------------------------
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    rstn_in = 1'b0;
    regs_in = '0;
    other_ext_in = 2'h0;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (6) @(negedge mclk_in);
    rstn_in = 1'b1;
    foreach (corner[i]) run_one(corner[i], i[0], 1'b1);
    $display("test corner done");
    rstn_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    check("reset done", done_out, 1'b0);
    check("reset form", decode_out.form, FORM_BAD);
    rstn_in = 1'b1;
    $display("test reset done");
    repeat (300) begin
      rnd = xs();
      run_one(rnd[7:0], rnd[9], 1'b1);
    end
    $display("test random done");
    other_ext_in = 2'h2;
    run_one(8'h45, 1'b0, 1'b0);
    $display("test non indexed done");
    close_out();
  end
endmodule
